// [sim/dtp_probe_model.sv]
module dtp_probe_model
(
	output logic tck_out,
	output logic trst_n_out,
	output logic tdi_out,
	output logic line_out,
	input  logic tdo_in,
	input  logic dev_data_in,
	input  logic dev_oe_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tms_r;
	logic drv_r;
	logic smp_tdo;
	logic smp_data;
	logic smp_oe;

	// The data line has a pull-up, so a released line reads high.
	assign line_out = drv_r ? tms_r : (dev_oe_in ? dev_data_in : 1'b1);

	initial
	begin
		tck_out = 1'b0;
		trst_n_out = 1'b1;
		tdi_out = 1'b0;
		tms_r = 1'b1;
		drv_r = 1'b1;
	end

	// The clock only runs inside these tasks and rests low between frames.
	task automatic clk1(input logic tms, input logic di);
		tms_r = tms;
		tdi_out = di;
		#24;
		smp_tdo = tdo_in;
		smp_data = dev_data_in;
		smp_oe = dev_oe_in;
		tck_out = 1'b1;
		#24;
		tck_out = 1'b0;
	endtask : clk1

	task automatic run(input logic [63:0] bits, input int n);
		for (int i = 0; i < n; i++)
			clk1(bits[i], 1'b0);
	endtask : run

	// The caller's value carries both TAPs' bits; no bypass is added here.
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		dout = '0;
		run(ir ? 64'h3 : 64'h1, ir ? 4 : 3);
		for (int i = 0; i < n; i++)
		begin
			clk1(i == n - 1, din[i]);
			dout[i] = smp_tdo;
		end
		run(64'h1, 2);
	endtask : scan

	task automatic switch_to(input logic [15:0] s);
		run('1, 50);
		run({48'h0, s}, 16);
		run('1, 50);
		run(64'h0, 4);
	endtask : switch_to

	task automatic swd_read(input logic [1:0] a, output logic [2:0] ack,
		output logic [32:0] dat, output int cnt);
		logic [7:0] hdr;
		hdr = {1'b1, 1'b0, a[0] ^ a[1], a[1], a[0], 3'b111};
		drv_r = 1'b1;
		for (int i = 0; i < 8; i++)
			clk1(hdr[i], 1'b0);
		drv_r = 1'b0;
		cnt = 0;
		ack = '0;
		dat = '0;
		for (int i = 0; i < 40; i++)
		begin
			clk1(1'b1, 1'b0);
			if (smp_oe === 1'b1)
			begin
				if (cnt < 3)
					ack[cnt] = smp_data;
				else
					dat[cnt - 3] = smp_data;
				cnt++;
			end
			else if (cnt > 0)
				break;
		end
		drv_r = 1'b1;
		run(64'h0, 8);
	endtask : swd_read
endmodule : dtp_probe_model

// [sim/dual_tap_serial_wire_debug_port_tb_top.sv]
module dual_tap_serial_wire_debug_port_tb_top
	import dtp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] TC_IDV = 32'h0A0B_0C01; // Arbitrary value.
	localparam logic [31:0] CORE_IDV = 32'h0D0E_0F03; // Arbitrary value.
	logic clk_sys, rst, tck, trst_n, tdi, line, tdo, tdo_oe, ms_out, ms_oe;
	logic swd_mode, req, we, ack, err, halted, halt, step, err_mode, s_we;
	logic [31:0] addr, wdata, rdata, s_addr, s_wd;
	int err_total, check_count, step_seen, bus_cnt;

	dtp_debug_port #(.TC_ID(TC_IDV), .CORE_ID(CORE_IDV)) i_dut (
		.clk_sys_in(clk_sys), .rst_in(rst), .jtag_clock_pin_in(tck),
		.jtag_reset_pin_n_in(trst_n), .jtag_data_in_pin_in(tdi),
		.jtag_mode_select_pin_in(line), .jtag_mode_select_pin_out(ms_out),
		.jtag_mode_select_pin_oe_out(ms_oe), .jtag_data_out_pin_out(tdo),
		.jtag_data_out_pin_oe_out(tdo_oe), .swd_mode_out(swd_mode),
		.sysbus_req_out(req), .sysbus_we_out(we), .sysbus_addr_out(addr),
		.sysbus_wdata_out(wdata), .sysbus_rdata_in(rdata),
		.sysbus_ack_in(ack), .sysbus_err_in(err), .cpu_halted_in(halted),
		.cpu_halt_out(halt), .cpu_step_out(step));

	dtp_probe_model i_probe (.tck_out(tck), .trst_n_out(trst_n),
		.tdi_out(tdi), .line_out(line), .tdo_in(tdo), .dev_data_in(ms_out),
		.dev_oe_in(ms_oe));

	always #20 clk_sys = ~clk_sys;

	// The bus answers one cycle after each request and logs what it saw.
	always @(posedge clk_sys)
	begin
		ack <= req & ~ack;
		err <= err_mode;
		rdata <= 32'h5A5A_1234;
		if (req === 1'b1 && ack === 1'b0)
		begin
			s_we <= we;
			s_addr <= addr;
			s_wd <= wdata;
			bus_cnt <= bus_cnt + 1;
		end
		if (step === 1'b1)
			step_seen <= step_seen + 1;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
				exp);
		end
	endtask : chk

	task automatic finish_test;
		if (err_total == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	task automatic acc(input logic rnw, input logic [1:0] a,
		input logic [31:0] d, output logic [34:0] cap);
		logic [63:0] o;
		i_probe.scan(1'b0, 36, {29'h0, d, a, rnw}, o);
		cap = o[34:0];
		chk(o[35], 1'b0);
		repeat (12) @(posedge clk_sys);
		// Idle clocks in run-test let the acknowledge reach the link side.
		i_probe.run(64'h0, 4);
	endtask : acc

	task automatic t_reset;
		chk({swd_mode, tdo_oe, ms_oe, req, halt, step}, 6'h00);
	endtask : t_reset

	task automatic t_chain;
		logic [63:0] o;
		i_probe.run(64'h1F, 6);
		i_probe.scan(1'b0, 64, '0, o);
		chk(o, {TC_IDV, CORE_IDV});
		i_probe.scan(1'b1, 8, {IR_BYPASS, IR_BYPASS}, o);
		chk(o[7:0], {IR_CAPTURE, IR_CAPTURE});
		i_probe.scan(1'b0, 10, 64'h2D5, o);
		chk(o[9:0], {8'hD5, 2'b00});
		i_probe.scan(1'b1, 8, {IR_BYPASS, IR_IDCODE}, o);
		i_probe.scan(1'b0, 33, '0, o);
		chk(o[32:0], {1'b0, CORE_IDV});
	endtask : t_chain

	task automatic t_access;
		logic [63:0] o;
		logic [34:0] c;
		i_probe.scan(1'b1, 8, {IR_BYPASS, IR_ACCESS}, o);
		@(posedge clk_sys);
		halted <= 1'b1;
		acc(1'b0, AP_TAR, 32'h2000_0010, c);
		acc(1'b0, AP_DATA, 32'hCAFE_0123, c);
		chk({s_we, s_addr, s_wd}, {1'b1, 32'h2000_0010, 32'hCAFE_0123});
		chk(bus_cnt, 1);
		acc(1'b1, AP_DATA, 32'h0, c);
		chk({s_we, s_addr}, {1'b0, 32'h2000_0014});
		acc(1'b1, AP_STAT, 32'h0, c);
		chk(c, {32'h5A5A_1234, ACK_OK});
		acc(1'b1, AP_STAT, 32'h0, c);
		chk(c, {32'h0000_0001, ACK_OK});
		acc(1'b0, AP_CTRL, 32'h0000_0003, c);
		chk({halt, 8'(step_seen)}, {1'b1, 8'h01});
		@(posedge clk_sys);
		err_mode <= 1'b1;
		acc(1'b1, AP_DATA, 32'h0, c);
		err_mode <= 1'b0;
		acc(1'b1, AP_STAT, 32'h0, c);
		chk(c[2:0], ACK_FAULT);
		acc(1'b1, AP_STAT, 32'h0, c);
		chk(c[4:3], 2'b11);
	endtask : t_access

	task automatic t_swd;
		logic [2:0] k;
		logic [32:0] d;
		logic [63:0] o;
		int n;
		i_probe.switch_to(SEQ_TO_SWD);
		chk(swd_mode, 1'b1);
		i_probe.swd_read(2'h3, k, d, n);
		i_probe.swd_read(2'h3, k, d, n);
		chk({6'(n), k}, {6'd36, ACK_OK});
		chk(d, {1'b0, 32'h0000_0003});
		chk(tdo_oe, 1'b0);
		i_probe.switch_to(SEQ_TO_JTAG);
		chk(swd_mode, 1'b0);
		i_probe.scan(1'b0, 64, '0, o);
		chk(o, {TC_IDV, CORE_IDV});
	endtask : t_swd

	initial
	begin
		clk_sys = 1'b0;
		rst = 1'b1;
		{ack, err, err_mode, halted} = 4'h0;
		rdata = '0;
		{err_total, check_count, step_seen, bus_cnt} = '0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_chain();
		t_access();
		t_swd();
		finish_test();
	end
endmodule : dual_tap_serial_wire_debug_port_tb_top

// [src/dtp_debug_port.sv]
// Function
// RQ1: Two four-bit-instruction TAPs in series, test controller first, core second.
// RQ2: Probe loads bypass into the test controller before reaching the core.
// RQ3: Every instruction shift spans eight bits; the idle TAP gets bypass.
// RQ4: The bypassed TAP adds one bit to each data scan.
// RQ5: Serial-wire selection forces the test controller's mode-select input high.
// RQ6: Serial data and clock share the mode-select and clock pins.
// RQ7: Five shared pins: reset, data out, data in, data/select, clock.
// RQ8: Probe requests pass to an access port running system bus transfers.
// RQ9: Non-intrusive memory and register access plus halt and single step.
// RQ10: Two-wire bidirectional protocol with parity error detection.
// RQ11: Shared clock and select, sixteen-state controllers, data-in to data-out chain.
module dtp_debug_port
	import dtp_pkg::*;
#(
	parameter logic [31:0] TC_ID   = 32'h1000_0001,
	parameter logic [31:0] CORE_ID = 32'h2000_0001
)
(
	input  logic        clk_sys_in,
	input  logic        rst_in,
	input  logic        jtag_clock_pin_in,
	input  logic        jtag_reset_pin_n_in,
	input  logic        jtag_data_in_pin_in,
	input  logic        jtag_mode_select_pin_in,
	output logic        jtag_mode_select_pin_out,
	output logic        jtag_mode_select_pin_oe_out,
	output logic        jtag_data_out_pin_out,
	output logic        jtag_data_out_pin_oe_out,
	output logic        swd_mode_out,
	output logic        sysbus_req_out,
	output logic        sysbus_we_out,
	output logic [31:0] sysbus_addr_out,
	output logic [31:0] sysbus_wdata_out,
	input  logic [31:0] sysbus_rdata_in,
	input  logic        sysbus_ack_in,
	input  logic        sysbus_err_in,
	input  logic        cpu_halted_in,
	output logic        cpu_halt_out,
	output logic        cpu_step_out
);

	typedef enum {SW_IDLE, SW_REQ, SW_TRN1, SW_ACK, SW_RD, SW_TRN2, SW_WR}
		dtp_sw_t;
	typedef enum {AP_IDLE, AP_BUS} dtp_ap_t;

	// Link side: everything below up to the access port runs on the pin clock.
	wire              link_rst = rst_in | ~jtag_reset_pin_n_in;
	wire              din      = jtag_mode_select_pin_in; // RQ6
	logic [15:0]      seq_r;
	logic [5:0]       ones_r;
	logic             armed_r;
	logic             swd_r;
	wire  [15:0]      seq_nxt  = {din, seq_r[15:1]};
	// Ones from the fiftieth on keep the serial engine idle, so a long reset
	// run cannot be taken for the start of a request.
	wire              line_rst = din && (ones_r >= LINE_ONES - 6'h01);
	wire              to_swd   = armed_r && !swd_r && seq_nxt == SEQ_TO_SWD;
	wire              to_jtag  = armed_r && swd_r && seq_nxt == SEQ_TO_JTAG;

	always_ff @(posedge jtag_clock_pin_in or posedge link_rst)
		if (link_rst)
		begin
			seq_r   <= '0;
			ones_r  <= '0;
			armed_r <= 1'b0;
			swd_r   <= 1'b0;
		end
		else
		begin
			seq_r   <= seq_nxt;
			ones_r  <= !din ? '0 : (ones_r == LINE_ONES) ? ones_r
				: ones_r + 6'h01;
			armed_r <= line_rst | (armed_r & ~(to_swd | to_jtag));
			swd_r   <= to_swd | (swd_r & ~to_jtag); // RQ6
		end

	// Both controllers are parked in reset while the serial protocol owns
	// the select pin, so serial traffic cannot wander through their states.
	wire              tms_tap = swd_r | din; // RQ5
	logic             tc_tdo;
	logic             tc_tlr;
	logic             core_tdo;
	logic             core_shift;
	logic             core_shir;
	logic             j_upd;
	logic [ACC_W-1:0] j_dr;
	logic [ACC_W-1:0] j_cap;

	dtp_tap #(.HAS_ACC(1'b0), .ID_CODE(TC_ID)) u_tc (
		.tck_in      (jtag_clock_pin_in),
		.rst_in      (link_rst),
		.tms_in      (tms_tap),
		.tdi_in      (jtag_data_in_pin_in),
		.tdo_out     (tc_tdo),
		.shift_out   (),
		.shir_out    (),
		.tlr_out     (tc_tlr),
		.upd_acc_out (),
		.dr_out      (),
		.cap_in      ({ACC_W{1'b0}})
	); // RQ1

	dtp_tap #(.HAS_ACC(1'b1), .ID_CODE(CORE_ID)) u_core (
		.tck_in      (jtag_clock_pin_in),
		.rst_in      (link_rst),
		.tms_in      (tms_tap),
		.tdi_in      (tc_tdo),
		.tdo_out     (core_tdo),
		.shift_out   (core_shift),
		.shir_out    (core_shir),
		.tlr_out     (),
		.upd_acc_out (j_upd),
		.dr_out      (j_dr),
		.cap_in      (j_cap)
	); // RQ11

	logic             tdo_r;
	logic             tdo_oe_r;

	// Output changes on the falling edge so the probe samples a settled bit.
	always_ff @(negedge jtag_clock_pin_in or posedge link_rst)
		if (link_rst)
		begin
			tdo_r    <= 1'b0;
			tdo_oe_r <= 1'b0;
		end
		else
		begin
			tdo_r    <= core_tdo; // RQ3
			tdo_oe_r <= core_shift & ~swd_r; // RQ7
		end

	// Request handshake towards the access port.
	dtp_req_t         req_r;
	dtp_rsp_t         rsp_r;
	logic             req_tgl_r;
	logic             ack_tgl_r;
	logic             ack_s1_r;
	logic             ack_s2_r;
	logic             ack_s3_r;
	logic             ack_lvl_r;
	logic             drop_r;
	wire              busy    = req_tgl_r != ack_lvl_r;
	wire              j_issue = j_upd && !busy;
	wire  [2:0]       j_ack   = (busy | drop_r) ? ACK_WAIT
		: rsp_r.fault ? ACK_FAULT : ACK_OK;
	wire  dtp_req_t   j_req   = '{rnw: j_dr[0], addr: j_dr[2:1],
		wdata: j_dr[ACC_W-1:3]};
	assign j_cap = {rsp_r.rdata, j_ack};

	// Serial-wire engine.
	dtp_sw_t          sw_r;
	logic [5:0]       cnt_r;
	logic [32:0]      sh_r;
	logic [2:0]       ack_r;
	logic             rnw_r;
	logic [1:0]       addr_r;
	logic             dio_r;
	logic             dio_oe_r;
	logic             werr_r;
	wire              req_ok  = ~^sh_r[30:26] && !sh_r[31] && sh_r[32];
	wire  [2:0]       ack_nxt = busy ? ACK_WAIT : werr_r ? ACK_FAULT : ACK_OK;
	wire  [32:0]      rd_word = {^rsp_r.rdata, rsp_r.rdata};
	wire  [32:0]      wr_word = {din, sh_r[32:1]};
	wire              wr_ok   = ~^wr_word;
	wire              ack_end = sw_r == SW_ACK && cnt_r == ACK_LAST;
	wire              wr_end  = sw_r == SW_WR && cnt_r == DATA_LAST;
	wire              s_issue = (ack_end && ack_r == ACK_OK && rnw_r)
		|| (wr_end && wr_ok);
	wire  dtp_req_t   s_req   = '{rnw: rnw_r, addr: addr_r,
		wdata: wr_word[31:0]};

	always_ff @(posedge jtag_clock_pin_in or posedge link_rst)
		if (link_rst)
		begin
			sw_r     <= SW_IDLE;
			cnt_r    <= '0;
			sh_r     <= '0;
			ack_r    <= ACK_OK;
			rnw_r    <= 1'b0;
			addr_r   <= '0;
			dio_r    <= 1'b0;
			dio_oe_r <= 1'b0;
		end
		else if (!swd_r || line_rst)
		begin
			sw_r     <= SW_IDLE;
			dio_oe_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_r + 6'h01;
			case (sw_r)
			SW_IDLE:
				if (din)
				begin
					sw_r  <= SW_REQ;
					cnt_r <= '0;
				end
			SW_REQ:
			begin
				sh_r <= wr_word;
				if (cnt_r == REQ_LAST)
					sw_r <= SW_TRN1;
			end
			SW_TRN1:
				if (!req_ok)
					sw_r <= SW_IDLE; // RQ10
				else
				begin
					ack_r    <= ack_nxt;
					sh_r     <= {30'h0000_0000, ack_nxt};
					dio_r    <= ack_nxt[0];
					dio_oe_r <= 1'b1;
					rnw_r    <= sh_r[27];
					addr_r   <= sh_r[29:28];
					cnt_r    <= '0;
					sw_r     <= SW_ACK;
				end
			SW_ACK, SW_RD:
			begin
				sh_r  <= {1'b0, sh_r[32:1]};
				dio_r <= sh_r[1];
				if (ack_end && ack_r == ACK_OK && rnw_r)
				begin
					sh_r  <= rd_word;
					dio_r <= rd_word[0];
					cnt_r <= '0;
					sw_r  <= SW_RD;
				end
				else if (ack_end || cnt_r == DATA_LAST)
				begin
					dio_oe_r <= 1'b0;
					sw_r     <= SW_TRN2;
				end
			end
			SW_TRN2:
			begin
				cnt_r <= '0;
				sw_r  <= (ack_r == ACK_OK && !rnw_r) ? SW_WR : SW_IDLE;
			end
			SW_WR:
			begin
				sh_r <= wr_word;
				if (wr_end)
					sw_r <= SW_IDLE;
			end
			default: sw_r <= SW_IDLE;
			endcase
		end

	// A corrupted write is held as a fault until the next line reset.
	always_ff @(posedge jtag_clock_pin_in or posedge link_rst)
		if (link_rst)
		begin
			werr_r    <= 1'b0;
			drop_r    <= 1'b0;
			req_tgl_r <= 1'b0;
			req_r     <= '0;
			ack_s1_r  <= 1'b0;
			ack_s2_r  <= 1'b0;
			ack_s3_r  <= 1'b0;
			ack_lvl_r <= 1'b0;
		end
		else
		begin
			werr_r    <= (wr_end & ~wr_ok) | (werr_r & ~line_rst); // RQ10
			drop_r    <= (j_upd & busy) | (drop_r & ~j_issue);
			if (j_issue || s_issue)
			begin
				req_r     <= j_issue ? j_req : s_req; // RQ8
				req_tgl_r <= ~req_tgl_r;
			end
			ack_s1_r  <= ack_tgl_r;
			ack_s2_r  <= ack_s1_r;
			ack_s3_r  <= ack_s2_r;
			ack_lvl_r <= (ack_s2_r == ack_s3_r) ? ack_s3_r : ack_lvl_r;
		end

	// Access port on the system clock.
	dtp_ap_t          ap_r;
	logic             rq_s1_r;
	logic             rq_s2_r;
	logic             rq_s3_r;
	logic             rq_lvl_r;
	logic [31:0]      tar_r;
	logic [31:0]      wd_r;
	logic             we_r;
	logic             breq_r;
	logic             halt_r;
	logic             step_r;
	logic             buserr_r;
	logic [31:0]      ctrl_w;
	logic [31:0]      stat_w;
	wire              new_req = (rq_lvl_r != ack_tgl_r) && ap_r == AP_IDLE;
	wire  [31:0]      ap_rd   = (req_r.addr == AP_TAR) ? tar_r
		: (req_r.addr == AP_CTRL) ? ctrl_w : stat_w;

	always_comb
	begin
		ctrl_w              = '0;
		ctrl_w[CTRL_HALT]   = halt_r;
		stat_w              = '0;
		stat_w[STAT_HALTED] = cpu_halted_in;
		stat_w[STAT_BUSERR] = buserr_r;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
		if (rst_in)
		begin
			rq_s1_r  <= 1'b0;
			rq_s2_r  <= 1'b0;
			rq_s3_r  <= 1'b0;
			rq_lvl_r <= 1'b0;
		end
		else
		begin
			rq_s1_r  <= req_tgl_r;
			rq_s2_r  <= rq_s1_r;
			rq_s3_r  <= rq_s2_r;
			rq_lvl_r <= (rq_s2_r == rq_s3_r) ? rq_s3_r : rq_lvl_r;
		end

	always_ff @(posedge clk_sys_in or posedge rst_in)
		if (rst_in)
		begin
			ap_r      <= AP_IDLE;
			ack_tgl_r <= 1'b0;
			rsp_r     <= '0;
			tar_r     <= '0;
			wd_r      <= '0;
			we_r      <= 1'b0;
			breq_r    <= 1'b0;
			halt_r    <= 1'b0;
			step_r    <= 1'b0;
			buserr_r  <= 1'b0;
		end
		else
		begin
			step_r <= 1'b0;
			if (new_req && req_r.addr == AP_DATA)
			begin
				breq_r <= 1'b1; // RQ8
				we_r   <= !req_r.rnw;
				wd_r   <= req_r.wdata;
				ap_r   <= AP_BUS;
			end
			else if (new_req)
			begin
				ack_tgl_r <= ~ack_tgl_r;
				rsp_r     <= '{rdata: ap_rd, fault: 1'b0};
				if (!req_r.rnw && req_r.addr == AP_TAR)
					tar_r <= req_r.wdata;
				if (!req_r.rnw && req_r.addr == AP_CTRL)
				begin
					halt_r <= req_r.wdata[CTRL_HALT]; // RQ9
					step_r <= req_r.wdata[CTRL_STEP];
				end
				if (!req_r.rnw && req_r.addr == AP_STAT
					&& req_r.wdata[STAT_BUSERR])
					buserr_r <= 1'b0;
			end
			else if (ap_r == AP_BUS && sysbus_ack_in)
			begin
				breq_r    <= 1'b0;
				ack_tgl_r <= ~ack_tgl_r;
				rsp_r     <= '{rdata: sysbus_rdata_in, fault: sysbus_err_in};
				buserr_r  <= buserr_r | sysbus_err_in;
				tar_r     <= tar_r + ADDR_STEP; // RQ9
				ap_r      <= AP_IDLE;
			end
		end

	localparam logic [3:0] CHAIN_LEN = 4'(2 * IR_W);
	logic [3:0]       shir_run_r;

	// Counts earlier back-to-back instruction shift cycles, saturating.
	always_ff @(posedge jtag_clock_pin_in or posedge link_rst)
		if (link_rst)
			shir_run_r <= '0;
		else
			shir_run_r <= !core_shir ? 4'h0
				: (shir_run_r == 4'hF) ? shir_run_r : shir_run_r + 4'h1;

	assign jtag_mode_select_pin_out    = dio_r;
	assign jtag_mode_select_pin_oe_out = dio_oe_r;
	assign jtag_data_out_pin_out       = tdo_r;
	assign jtag_data_out_pin_oe_out    = tdo_oe_r;
	assign swd_mode_out                = swd_r;
	assign sysbus_req_out              = breq_r;
	assign sysbus_we_out               = we_r;
	assign sysbus_addr_out             = tar_r;
	assign sysbus_wdata_out            = wd_r;
	assign cpu_halt_out                = halt_r;
	assign cpu_step_out                = step_r;

	a_chain_eight_bits: assert property ( // RQ3
		@(posedge jtag_clock_pin_in) disable iff (link_rst)
		core_shir && shir_run_r >= CHAIN_LEN
		|-> core_tdo == $past(jtag_data_in_pin_in, 8))
		else $error("instruction chain is not eight bits");

	a_tc_parked_swd: assert property ( // RQ5
		@(posedge jtag_clock_pin_in) disable iff (link_rst)
		swd_r [*6] |-> tc_tlr)
		else $error("test controller not held in reset");

	a_mode_switch: assert property ( // RQ6
		@(posedge jtag_clock_pin_in) disable iff (link_rst)
		armed_r && !swd_r && seq_nxt == SEQ_TO_SWD |=> swd_r && !armed_r)
		else $error("switching sequence did not select serial wire");

	a_tdo_off_swd: assert property ( // RQ7
		@(negedge jtag_clock_pin_in) disable iff (link_rst)
		swd_r |=> !jtag_data_out_pin_oe_out)
		else $error("data out driven in serial-wire mode");

	a_bad_req_silent: assert property ( // RQ10
		@(posedge jtag_clock_pin_in) disable iff (link_rst)
		swd_r && !line_rst && sw_r == SW_TRN1 && !req_ok
		|=> !jtag_mode_select_pin_oe_out [*3])
		else $error("driven after a request parity error");

	a_wait_when_busy: assert property ( // RQ10
		@(posedge jtag_clock_pin_in) disable iff (link_rst || line_rst)
		swd_r && sw_r == SW_TRN1 && req_ok && busy
		|=> (ack_r == ACK_WAIT && dio_oe_r) [*3] ##1 !dio_oe_r)
		else $error("busy request not answered with three-bit wait");

	a_bus_hold: assert property ( // RQ8
		@(posedge clk_sys_in) disable iff (rst_in)
		sysbus_req_out && !sysbus_ack_in
		|=> sysbus_req_out && $stable(sysbus_addr_out))
		else $error("bus request dropped before acknowledge");

	a_halt_write: assert property ( // RQ9
		@(posedge clk_sys_in) disable iff (rst_in)
		new_req && !req_r.rnw && req_r.addr == AP_CTRL
		|=> cpu_halt_out == $past(req_r.wdata[CTRL_HALT]))
		else $error("halt control not taken from write");

endmodule : dtp_debug_port

// [src/dtp_pkg.sv]
package dtp_pkg;

	localparam int          IR_W        = 4;
	localparam int          ID_W        = 32;
	localparam int          ACC_W       = 35;
	localparam logic [3:0]  IR_BYPASS   = 4'hF;
	localparam logic [3:0]  IR_IDCODE   = 4'hE;
	localparam logic [3:0]  IR_ACCESS   = 4'hA;
	localparam logic [3:0]  IR_CAPTURE  = 4'h1;

	localparam logic [15:0] SEQ_TO_SWD  = 16'hE79E;
	localparam logic [15:0] SEQ_TO_JTAG = 16'hE73C;
	localparam logic [5:0]  LINE_ONES   = 6'h32;
	localparam logic [5:0]  REQ_LAST    = 6'h06;
	localparam logic [5:0]  ACK_LAST    = 6'h02;
	localparam logic [5:0]  DATA_LAST   = 6'h20;
	localparam logic [2:0]  ACK_OK      = 3'h1;
	localparam logic [2:0]  ACK_WAIT    = 3'h2;
	localparam logic [2:0]  ACK_FAULT   = 3'h4;

	localparam logic [1:0]  AP_TAR      = 2'h0;
	localparam logic [1:0]  AP_DATA     = 2'h1;
	localparam logic [1:0]  AP_CTRL     = 2'h2;
	localparam logic [1:0]  AP_STAT     = 2'h3;
	localparam logic [31:0] ADDR_STEP   = 32'h0000_0004;
	localparam int          CTRL_HALT   = 0;
	localparam int          CTRL_STEP   = 1;
	localparam int          STAT_HALTED = 0;
	localparam int          STAT_BUSERR = 1;

	typedef struct packed {
		logic        rnw;
		logic [1:0]  addr;
		logic [31:0] wdata;
	} dtp_req_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic        fault;
	} dtp_rsp_t;

endpackage : dtp_pkg

// [src/dtp_tap.sv]
module dtp_tap
	import dtp_pkg::*;
#(
	parameter bit          HAS_ACC = 1'b0,
	parameter logic [31:0] ID_CODE = 32'h0000_0001
)
(
	input  logic             tck_in,
	input  logic             rst_in,
	input  logic             tms_in,
	input  logic             tdi_in,
	output logic             tdo_out,
	output logic             shift_out,
	output logic             shir_out,
	output logic             tlr_out,
	output logic             upd_acc_out,
	output logic [ACC_W-1:0] dr_out,
	input  logic [ACC_W-1:0] cap_in
);

	typedef enum {
		ST_TLR, ST_RTI, ST_SDR, ST_CDR, ST_SHD, ST_E1D, ST_PDR, ST_E2D,
		ST_UDR, ST_SIR, ST_CIR, ST_SHI, ST_E1I, ST_PIR, ST_E2I, ST_UIR
	} dtp_tst_t;

	dtp_tst_t         st_r;
	dtp_tst_t         st_nxt;
	logic [IR_W-1:0]  ir_r;
	logic [IR_W-1:0]  ir_sh_r;
	logic [ACC_W-1:0] dr_r;
	logic             byp_r;
	wire              is_acc = HAS_ACC && (ir_r == IR_ACCESS);
	wire              is_id  = (ir_r == IR_IDCODE);
	wire              is_byp = !is_acc && !is_id;
	wire [ACC_W-1:0]  id_ext = {{(ACC_W-ID_W){1'b0}}, ID_CODE};
	wire [ACC_W-1:0]  dr_sh  = is_acc ? {tdi_in, dr_r[ACC_W-1:1]}
		: {{(ACC_W-ID_W){1'b0}}, tdi_in, dr_r[ID_W-1:1]};

	// Standard sixteen-state controller on the shared clock and select.
	always_comb
	begin
		case (st_r) // RQ11
		ST_TLR:  st_nxt = tms_in ? ST_TLR : ST_RTI;
		ST_RTI:  st_nxt = tms_in ? ST_SDR : ST_RTI;
		ST_SDR:  st_nxt = tms_in ? ST_SIR : ST_CDR;
		ST_CDR:  st_nxt = tms_in ? ST_E1D : ST_SHD;
		ST_SHD:  st_nxt = tms_in ? ST_E1D : ST_SHD;
		ST_E1D:  st_nxt = tms_in ? ST_UDR : ST_PDR;
		ST_PDR:  st_nxt = tms_in ? ST_E2D : ST_PDR;
		ST_E2D:  st_nxt = tms_in ? ST_UDR : ST_SHD;
		ST_UDR:  st_nxt = tms_in ? ST_SDR : ST_RTI;
		ST_SIR:  st_nxt = tms_in ? ST_TLR : ST_CIR;
		ST_CIR:  st_nxt = tms_in ? ST_E1I : ST_SHI;
		ST_SHI:  st_nxt = tms_in ? ST_E1I : ST_SHI;
		ST_E1I:  st_nxt = tms_in ? ST_UIR : ST_PIR;
		ST_PIR:  st_nxt = tms_in ? ST_E2I : ST_PIR;
		ST_E2I:  st_nxt = tms_in ? ST_UIR : ST_SHI;
		ST_UIR:  st_nxt = tms_in ? ST_SDR : ST_RTI;
		default: st_nxt = ST_TLR;
		endcase
	end

	always_ff @(posedge tck_in or posedge rst_in)
		if (rst_in)
			st_r <= ST_TLR;
		else
			st_r <= st_nxt;

	// Four-bit instruction path; reset selects the identity register.
	always_ff @(posedge tck_in or posedge rst_in)
		if (rst_in)
		begin
			ir_r    <= IR_IDCODE;
			ir_sh_r <= IR_CAPTURE;
		end
		else
		begin
			if (st_r == ST_CIR)
				ir_sh_r <= IR_CAPTURE;
			else if (st_r == ST_SHI)
				ir_sh_r <= {tdi_in, ir_sh_r[IR_W-1:1]}; // RQ1
			if (st_r == ST_TLR)
				ir_r <= IR_IDCODE;
			else if (st_r == ST_UIR)
				ir_r <= ir_sh_r;
		end

	// Unknown codes fall back to bypass so the chain length stays known.
	always_ff @(posedge tck_in or posedge rst_in)
		if (rst_in)
		begin
			dr_r  <= '0;
			byp_r <= 1'b0;
		end
		else
		begin
			if (st_r == ST_CDR)
				dr_r <= is_acc ? cap_in : id_ext;
			else if (st_r == ST_SHD && !is_byp)
				dr_r <= dr_sh;
			if (st_r == ST_CDR)
				byp_r <= 1'b0;
			else if (st_r == ST_SHD)
				byp_r <= tdi_in; // RQ4
		end

	assign tdo_out     = (st_r == ST_SHI) ? ir_sh_r[0]
		: is_byp ? byp_r : dr_r[0];
	assign shift_out   = (st_r == ST_SHD) || (st_r == ST_SHI);
	assign shir_out    = (st_r == ST_SHI);
	assign tlr_out     = (st_r == ST_TLR);
	assign upd_acc_out = (st_r == ST_UDR) && is_acc;
	assign dr_out      = dr_r;

	a_tlr_five_ones: assert property ( // RQ11
		@(posedge tck_in) disable iff (rst_in)
		tms_in [*5] |=> st_r == ST_TLR)
		else $error("controller missed reset after five ones");

	a_ir_four_bits: assert property ( // RQ1
		@(posedge tck_in) disable iff (rst_in)
		(st_r == ST_SHI) [*5] |-> tdo_out == $past(tdi_in, 4))
		else $error("instruction path is not four bits");

	a_bypass_one_bit: assert property ( // RQ4
		@(posedge tck_in) disable iff (rst_in)
		(st_r == ST_SHD && is_byp) [*2] |-> tdo_out == $past(tdi_in))
		else $error("bypass does not add exactly one bit");

endmodule : dtp_tap
